// *** hdl/seq_ctrl_pkg.sv ***
// Constants and types shared by the sequence, timing and buffer control block
package seq_ctrl_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_SEQUENCE_STATE     = 8'h04;
    localparam logic [7:0] OFS_OSCILLATOR_SELECT  = 8'h18;
    localparam logic [7:0] OFS_CONV_CLOCK_COUNT   = 8'h19;
    localparam logic [7:0] OFS_BEGIN_SCAN         = 8'h1e;
    localparam logic [7:0] OFS_SEQUENCE_ABORT     = 8'h1f;
    localparam logic [7:0] OFS_OUTPUT_WORD_FORMAT = 8'h28;
    localparam logic [7:0] OFS_BUFFER_FILL_MODE   = 8'h2c;

    // ---------------------------------------------------------------
    // Reset values and field positions
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_OSCILLATOR_SELECT  = 8'h00;
    localparam logic [7:0] RST_CONV_CLOCK_COUNT   = 8'h00;
    localparam logic [1:0] RST_OUTPUT_WORD_FORMAT = 2'h0;
    localparam logic [2:0] RST_BUFFER_FILL_MODE   = 3'h1;
    localparam logic [1:0] RST_SCAN_STATE         = 2'h0;
    localparam int         POS_ABORT_SCAN_BIT     = 0;
    localparam int         POS_BEGIN_SCAN_BIT     = 0;
    localparam int         POS_OSC_CHOICE_BIT     = 0;
    localparam int         POS_SCAN_STATE_LSB     = 1;

    // ---------------------------------------------------------------
    // Field encodings and timing floors
    // ---------------------------------------------------------------
    localparam logic       OSC_HIGH_SPEED         = 1'b0;
    localparam logic       OSC_LOW_POWER          = 1'b1;
    localparam logic [7:0] MIN_COUNT_HIGH_SPEED   = 8'h15;
    localparam logic [7:0] MIN_COUNT_LOW_POWER    = 8'h12;
    localparam logic [1:0] SCAN_OFF_OK            = 2'h0;
    localparam logic [1:0] SCAN_ON_OK             = 2'h1;
    localparam logic [1:0] SCAN_ON_ERROR          = 2'h3;
    localparam logic [2:0] FILL_STOP_BURST        = 3'h0;
    localparam logic [2:0] FILL_START_BURST       = 3'h1;
    localparam logic [2:0] FILL_PRE_ALERT         = 3'h4;
    localparam logic [2:0] FILL_POST_ALERT        = 3'h6;
    localparam logic [1:0] FMT_ZERO_PAD           = 2'h0;
    localparam logic [1:0] FMT_CHANNEL_TAG        = 2'h1;
    localparam logic [1:0] FMT_TAG_AND_VALID      = 2'h2;
    localparam logic [1:0] FMT_ZERO_PAD_ALT       = 2'h3;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wrData;
    } reg_req_t;

    typedef struct packed {
        logic [11:0] result;
        logic        channel;
        logic        valid;
    } conv_sample_t;
endpackage

// *** hdl/sequence_timing_buffer_ctrl.sv ***
// Sequence, conversion timing and data buffer control registers
`timescale 1ns/100ps

module sequence_timing_buffer_ctrl
    import seq_ctrl_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         clkEn,
    input  wire reg_req_t     regReq,
    output logic [7:0]        regRdData,
    input  wire logic         genCallRst,
    input  wire logic         autoSeqEnabled,
    input  wire logic         deviceError,
    input  wire logic         hsOscPin,
    input  wire logic         lpOscPin,
    input  wire conv_sample_t sample,
    output logic              busy,
    output logic              oscChoice,
    output logic [7:0]        cycleClockCount,
    output logic [2:0]        bufferFillMode,
    output logic [15:0]       bufWord,
    output logic              bufWordStrobe
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] clampCount(input logic [7:0] raw, input logic osc);
        logic [7:0] floorVal;
        floorVal = (osc == OSC_LOW_POWER) ? MIN_COUNT_LOW_POWER : MIN_COUNT_HIGH_SPEED;
        clampCount = (raw <= floorVal) ? floorVal : raw;
    endfunction

    function automatic logic [15:0] packWord(input conv_sample_t s, input logic [1:0] fmt);
        packWord = {s.result, 4'h0};
        if (fmt == FMT_CHANNEL_TAG) begin
            // Tag sits in bits 3-1 as 00 then channel, bit 0 stays zero
            packWord = {s.result, 2'h0, s.channel, 1'b0};
        end else if (fmt == FMT_TAG_AND_VALID) begin
            packWord = {s.result, 2'h0, s.channel, s.valid};
        end
    endfunction

    // ---------------------------------------------------------------
    // Register write decode
    // ---------------------------------------------------------------
    logic       wrStrobe;
    logic       beginScan;
    logic       abortScan;
    logic       resetAll;
    logic [7:0] rawCount;
    logic [1:0] outputFormat;
    logic [1:0] scanState;

    assign wrStrobe  = clkEn & regReq.write;
    assign resetAll  = sys_rst | genCallRst;
    assign beginScan = wrStrobe && regReq.addr == OFS_BEGIN_SCAN && regReq.wrData[POS_BEGIN_SCAN_BIT];
    // Abort is never stored, it acts only in the cycle of the write
    assign abortScan = wrStrobe && regReq.addr == OFS_SEQUENCE_ABORT
                       && regReq.wrData[POS_ABORT_SCAN_BIT];

    always_ff @(posedge clk) begin
        if (resetAll) begin
            oscChoice      <= RST_OSCILLATOR_SELECT[POS_OSC_CHOICE_BIT];
            rawCount       <= RST_CONV_CLOCK_COUNT;
            outputFormat   <= RST_OUTPUT_WORD_FORMAT;
            bufferFillMode <= RST_BUFFER_FILL_MODE;
        end else if (wrStrobe) begin
            if (regReq.addr == OFS_OSCILLATOR_SELECT) begin
                oscChoice <= regReq.wrData[POS_OSC_CHOICE_BIT];
            end else if (regReq.addr == OFS_CONV_CLOCK_COUNT) begin
                rawCount <= regReq.wrData;
            end else if (regReq.addr == OFS_OUTPUT_WORD_FORMAT) begin
                outputFormat <= regReq.wrData[1:0];
            end else if (regReq.addr == OFS_BUFFER_FILL_MODE) begin
                bufferFillMode <= regReq.wrData[2:0];
            end
        end
    end

    // Floor follows the oscillator in use, so changing oscillator re-clamps
    assign cycleClockCount = clampCount(rawCount, oscChoice);

    // ---------------------------------------------------------------
    // Oscillator pin synchronisers
    // ---------------------------------------------------------------
    logic [1:0] hsSync;
    logic [1:0] lpSync;
    logic       selLevel;
    logic       selLevelQ;
    logic       oscTick;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hsSync    <= 2'h0;
            lpSync    <= 2'h0;
            selLevelQ <= 1'b0;
        end else if (clkEn) begin
            hsSync    <= {hsSync[0], hsOscPin};
            lpSync    <= {lpSync[0], lpOscPin};
            selLevelQ <= selLevel;
        end
    end

    assign selLevel = (oscChoice == OSC_LOW_POWER) ? lpSync[1] : hsSync[1];
    assign oscTick  = selLevel & ~selLevelQ;

    // ---------------------------------------------------------------
    // Conversion cycle timer
    // ---------------------------------------------------------------
    logic [7:0] tickCount;
    logic       cycleDone;

    assign cycleDone = busy && oscTick && (tickCount + 8'h01 >= cycleClockCount);

    always_ff @(posedge clk) begin
        if (resetAll) begin
            busy      <= 1'b0;
            tickCount <= 8'h00;
        end else if (clkEn) begin
            if (abortScan) begin
                busy      <= 1'b0;
                tickCount <= 8'h00;
            end else if (beginScan) begin
                busy      <= 1'b1;
                tickCount <= 8'h00;
            end else if (cycleDone) begin
                tickCount <= 8'h00;
            end else if (busy && oscTick) begin
                tickCount <= tickCount + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (resetAll) begin
            bufWord       <= 16'h0000;
            bufWordStrobe <= 1'b0;
        end else if (clkEn) begin
            bufWordStrobe <= cycleDone && !abortScan;
            if (cycleDone && !abortScan) begin
                bufWord <= packWord(sample, outputFormat);
            end
        end
    end

    // ---------------------------------------------------------------
    // Sequence status
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (resetAll) begin
            scanState <= RST_SCAN_STATE;
        end else if (clkEn) begin
            if (beginScan) begin
                scanState <= RST_SCAN_STATE;
            end else if (busy && autoSeqEnabled) begin
                scanState <= deviceError ? SCAN_ON_ERROR : SCAN_ON_OK;
            end else begin
                scanState <= SCAN_OFF_OK;
            end
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (clkEn && regReq.read) begin
            if (regReq.addr == OFS_SEQUENCE_STATE) begin
                regRdData <= {5'h00, scanState, 1'b0};
            end else if (regReq.addr == OFS_OSCILLATOR_SELECT) begin
                regRdData <= {7'h00, oscChoice};
            end else if (regReq.addr == OFS_CONV_CLOCK_COUNT) begin
                regRdData <= rawCount;
            end else if (regReq.addr == OFS_OUTPUT_WORD_FORMAT) begin
                regRdData <= {6'h00, outputFormat};
            end else if (regReq.addr == OFS_BUFFER_FILL_MODE) begin
                regRdData <= {5'h00, bufferFillMode};
            end else begin
                regRdData <= 8'h00;
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    sequence seqAbortWrite;
        !sys_rst && clkEn && regReq.write && regReq.addr == OFS_SEQUENCE_ABORT && regReq.wrData[0];
    endsequence

    sequence seqStartWrite;
        !sys_rst && !genCallRst && clkEn && regReq.write && regReq.addr == OFS_BEGIN_SCAN
        && regReq.wrData[0] && !abortScan;
    endsequence

    AST_ABORT_DROPS_BUSY: assert property (@(posedge clk) disable iff (sys_rst)
        seqAbortWrite |=> !busy)
        else $error("busy still high after abort");

    AST_START_CLEARS_STATE: assert property (@(posedge clk) disable iff (sys_rst)
        seqStartWrite |=> scanState == RST_SCAN_STATE)
        else $error("status not cleared by scan start");

    AST_STATE_CODE_LEGAL: assert property (@(posedge clk) disable iff (sys_rst)
        scanState != 2'h2)
        else $error("unused scan state code reported");

    AST_STATE_OFF_WHEN_DISABLED: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && !autoSeqEnabled |=> scanState == SCAN_OFF_OK)
        else $error("scan state not off while sequencing disabled");

    AST_STATUS_RESERVED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regReq.read && regReq.addr == OFS_SEQUENCE_STATE
        |=> regRdData[7:3] == 5'h00 && regRdData[0] == 1'b0)
        else $error("status reserved bits not zero");

    AST_OSC_UPPER_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regReq.read && regReq.addr == OFS_OSCILLATOR_SELECT
        |=> regRdData[7:1] == 7'h00 && regRdData[0] == $past(oscChoice))
        else $error("oscillator select readback wrong");

    AST_FAST_FLOOR: assert property (@(posedge clk) disable iff (sys_rst)
        oscChoice == OSC_HIGH_SPEED |-> cycleClockCount >= 8'h15
        && (rawCount > 8'h15 ? cycleClockCount == rawCount : cycleClockCount == 8'h15))
        else $error("fast oscillator count floor wrong");

    AST_SLOW_FLOOR: assert property (@(posedge clk) disable iff (sys_rst)
        oscChoice == OSC_LOW_POWER |-> cycleClockCount >= 8'h12
        && (rawCount > 8'h12 ? cycleClockCount == rawCount : cycleClockCount == 8'h12))
        else $error("low-power oscillator count floor wrong");

    AST_START_RAISES_BUSY: assert property (@(posedge clk) disable iff (sys_rst)
        seqStartWrite |=> busy ##0 tickCount == 8'h00)
        else $error("scan start did not raise busy");

    AST_ABORT_READS_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        clkEn && regReq.read && regReq.addr == OFS_SEQUENCE_ABORT |=> regRdData == 8'h00)
        else $error("abort register did not read zero");

    AST_WORD_TAGGED: assert property (@(posedge clk) disable iff (sys_rst)
        bufWordStrobe && $past(outputFormat) == FMT_TAG_AND_VALID
        |-> bufWord[3:1] == {2'h0, $past(sample.channel)} && bufWord[0] == $past(sample.valid))
        else $error("tagged buffer word malformed");

    AST_STROBE_ONLY_BUSY: assert property (@(posedge clk) disable iff (sys_rst)
        bufWordStrobe |-> $past(busy))
        else $error("buffer word stored while idle");
endmodule // sequence_timing_buffer_ctrl

// *** tb/osc_source.sv ***
// Free-running oscillator pin model for the conversion clock inputs
`timescale 1ns/100ps
module osc_source #(
    parameter int HS_HALF = 2,
    parameter int LP_HALF = 3
) (
    input  wire logic clk,
    output logic      hsOscPin,
    output logic      lpOscPin
);
    int hsCnt = 0;
    int lpCnt = 0;
    initial begin
        hsOscPin = 1'b0;
        lpOscPin = 1'b0;
    end
    // Each level holds at least two system clocks so every edge is seen
    always @(posedge clk) begin
        hsCnt <= (hsCnt == HS_HALF - 1) ? 0 : hsCnt + 1;
        lpCnt <= (lpCnt == LP_HALF - 1) ? 0 : lpCnt + 1;
        if (hsCnt == HS_HALF - 1) hsOscPin <= ~hsOscPin;
        if (lpCnt == LP_HALF - 1) lpOscPin <= ~lpOscPin;
    end
endmodule // osc_source

// *** tb/test_sequence_timing_buffer_ctrl.sv ***
// Register-level testbench for the sequence, timing and buffer control block
`timescale 1ns/100ps
module test_sequence_timing_buffer_ctrl;
    import seq_ctrl_pkg::*;
    logic clk = 1'b0, sysRst = 1'b1, clkEn = 1'b1, genCallRst = 1'b0;
    logic autoSeqEnabled = 1'b0, deviceError = 1'b0, hsOscPin, lpOscPin;
    reg_req_t regReq = '0;
    conv_sample_t sample = '{result: 12'habc, channel: 1'b1, valid: 1'b1};
    logic [7:0] regRdData, cycleClockCount;
    logic busy, oscChoice, bufWordStrobe;
    logic [2:0] bufferFillMode;
    logic [15:0] bufWord;
    int miscompares = 0, comparisons = 0, cyc = 0, lastStrobe = 0, gap = 0;
    logic [7:0] cnts [6] = '{8'h00, 8'h12, 8'h13, 8'h15, 8'h16, 8'hff};
    logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h4, 3'h6};
    logic [7:0] fl;
    logic [3:0] tail;

    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    osc_source OSC (.clk(clk), .hsOscPin(hsOscPin), .lpOscPin(lpOscPin));
    sequence_timing_buffer_ctrl DUT (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn), .regReq(regReq),
        .regRdData(regRdData), .genCallRst(genCallRst), .autoSeqEnabled(autoSeqEnabled),
        .deviceError(deviceError), .hsOscPin(hsOscPin), .lpOscPin(lpOscPin), .sample(sample),
        .busy(busy), .oscChoice(oscChoice), .cycleClockCount(cycleClockCount),
        .bufferFillMode(bufferFillMode), .bufWord(bufWord), .bufWordStrobe(bufWordStrobe));

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #2 regReq = '{write: 1'b1, read: 1'b0, addr: a, wrData: d};
        @(posedge clk) #2 regReq = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) #2 regReq = '{write: 1'b0, read: 1'b1, addr: a, wrData: 8'h00};
        @(posedge clk) #2 regReq = '0;
        chk($sformatf("reg %h", a), {8'h00, regRdData}, {8'h00, exp});
    endtask
    task automatic waitStrobe();
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge clk) #1;
            if (bufWordStrobe === 1'b1) break;
        end
        chk("strobe seen", {15'h0, bufWordStrobe}, 16'h0001);
        gap = cyc - lastStrobe;
        lastStrobe = cyc;
    endtask
    task automatic final_report();
        if (miscompares == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        miscompares++;
        final_report();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        #2 sysRst = 1'b0;
        rd(OFS_SEQUENCE_STATE, 8'h00);
        rd(OFS_OSCILLATOR_SELECT, 8'h00);
        rd(OFS_CONV_CLOCK_COUNT, 8'h00);
        rd(OFS_SEQUENCE_ABORT, 8'h00);
        rd(OFS_OUTPUT_WORD_FORMAT, 8'h00);
        rd(OFS_BUFFER_FILL_MODE, 8'h01);
        chk("count", {8'h0, cycleClockCount}, 16'h0015);
        for (int o = 0; o < 2; o++) begin
            fl = o ? 8'd18 : 8'd21;
            foreach (cnts[i]) begin
                wr(OFS_OSCILLATOR_SELECT, o ? 8'hff : 8'hfe);
                wr(OFS_CONV_CLOCK_COUNT, cnts[i]);
                chk("osc", {15'h0, oscChoice}, o[15:0]);
                chk("count", {8'h0, cycleClockCount}, {8'h0, cnts[i] <= fl ? fl : cnts[i]});
                rd(OFS_OSCILLATOR_SELECT, o[7:0]);
                rd(OFS_CONV_CLOCK_COUNT, cnts[i]);
            end
        end
        foreach (modes[i]) begin
            wr(OFS_BUFFER_FILL_MODE, {5'h0, modes[i]});
            rd(OFS_BUFFER_FILL_MODE, {5'h0, modes[i]});
            chk("fill", {13'h0, bufferFillMode}, {13'h0, modes[i]});
        end
        wr(8'h3f, 8'hff);
        rd(8'h3f, 8'h00);
        autoSeqEnabled = 1'b1;
        wr(OFS_OSCILLATOR_SELECT, 8'h00);
        wr(OFS_CONV_CLOCK_COUNT, 8'h16);
        wr(OFS_BEGIN_SCAN, 8'h01);
        chk("busy", {15'h0, busy}, 16'h0001);
        rd(OFS_SEQUENCE_STATE, 8'h02);
        deviceError = 1'b1;
        rd(OFS_SEQUENCE_STATE, 8'h06);
        autoSeqEnabled = 1'b0;
        rd(OFS_SEQUENCE_STATE, 8'h00);
        autoSeqEnabled = 1'b1;
        wr(OFS_BEGIN_SCAN, 8'h01);
        deviceError = 1'b0;
        for (int f = 0; f < 4; f++) begin
            wr(OFS_OUTPUT_WORD_FORMAT, f[7:0]);
            waitStrobe();
            waitStrobe();
            tail = (f == 1) ? 4'b0010 : (f == 2) ? 4'b0011 : 4'b0000;
            chk("word", bufWord, {12'habc, tail});
            chk("hs cycle", gap[15:0], 16'd88);
        end
        wr(OFS_OSCILLATOR_SELECT, 8'h01);
        wr(OFS_CONV_CLOCK_COUNT, 8'h05);
        repeat (3) waitStrobe();
        chk("lp cycle", gap[15:0], 16'd108);
        wr(OFS_SEQUENCE_ABORT, 8'h01);
        chk("busy", {15'h0, busy}, 16'h0000);
        rd(OFS_SEQUENCE_STATE, 8'h00);
        rd(OFS_SEQUENCE_ABORT, 8'h00);
        gap = 0;
        repeat (150) begin
            @(posedge clk) #1;
            if (bufWordStrobe === 1'b1) gap++;
        end
        chk("strobes after stop", gap[15:0], 16'h0000);
        wr(OFS_BUFFER_FILL_MODE, 8'h04);
        wr(OFS_OUTPUT_WORD_FORMAT, 8'h02);
        wr(OFS_BEGIN_SCAN, 8'h01);
        @(posedge clk) #2 genCallRst = 1'b1;
        @(posedge clk) #2 genCallRst = 1'b0;
        chk("busy", {15'h0, busy}, 16'h0000);
        rd(OFS_SEQUENCE_STATE, 8'h00);
        rd(OFS_BUFFER_FILL_MODE, 8'h01);
        rd(OFS_OUTPUT_WORD_FORMAT, 8'h00);
        rd(OFS_OSCILLATOR_SELECT, 8'h00);
        chk("count", {8'h0, cycleClockCount}, 16'h0015);
        clkEn = 1'b0;
        wr(OFS_OSCILLATOR_SELECT, 8'h01);
        clkEn = 1'b1;
        rd(OFS_OSCILLATOR_SELECT, 8'h00);
        final_report();
    end
endmodule // test_sequence_timing_buffer_ctrl
